/* File: src/ssrx_defs.svh */
/*
  Constants of the synchronous character-framing receiver: widths,
  reset values and encodings. Definitions only; included by the package.
*/
`ifndef SSRX_DEFS_SVH
`define SSRX_DEFS_SVH

// ************************************************************
// widths
// ************************************************************
`define SSRX_CHAR_W 8
`define SSRX_OUT_W 9
`define SSRX_MODE_W 3
`define SSRX_WLS_W 2
`define SSRX_CNT_W 4
`define SSRX_FIFO_DEPTH 8

// ************************************************************
// field positions of a queued character entry
// ************************************************************
`define SSRX_ENT_W 11
`define SSRX_ENT_PAR 8
`define SSRX_ENT_PERR 9
`define SSRX_ENT_SYNC 10

// ************************************************************
// encodings and reset values
// ************************************************************
`define SSRX_MODE_SYNC_INT 3'h7
`define SSRX_MODE_SYNC_EXT 3'h6
`define SSRX_MODE_RST 3'h7
`define SSRX_WLS_RST 2'h3
`define SSRX_MATCH_RST 8'h00
`define SSRX_PAR_OFF_RST 1'h1
`define SSRX_EVEN_RST 1'h0
`define SSRX_WL_BASE 4'h5
`define SSRX_WL_MAX 4'h8

`endif

/* File: src/ssrx_fifo.sv */
/*
  Flip-flop character queue with valid/ready on both sides.
  Assumes synchronous active-high reset and a common clock enable.
*/
`timescale 1ns/1ps

module ssrx_fifo #(
  parameter int W = 11,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // streams
  ssrx_stream_if.snk wr,
  ssrx_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data = mem_q[rp_q];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_comb begin
    wp_d = push ? AW'((wp_q + 1'b1) % DEPTH) : wp_q;
    rp_d = pop ? AW'((rp_q + 1'b1) % DEPTH) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // ************************************************************
  // storage
  // ************************************************************
  genvar i;
  for (i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk) begin
      if (ce && push && wp_q == AW'(i)) begin
        mem_q[i] <= wr.data;
      end
    end
  end
endmodule : ssrx_fifo

/* File: src/ssrx_pkg.sv */
/*
  Types of the synchronous character-framing receiver.
  Assumes ssrx_defs.svh is on the include path.
*/
`include "ssrx_defs.svh"

package ssrx_pkg;

  // ************************************************************
  // framing states
  // ************************************************************
  typedef enum logic [1:0] {
    SSRX_HUNT = 2'h1,
    SSRX_ASM = 2'h2
  } ssrx_state_t;

  typedef logic [`SSRX_MODE_W-1:0] ssrx_mode_t;
  typedef logic [`SSRX_WLS_W-1:0] ssrx_wls_t;
  typedef logic [`SSRX_CHAR_W-1:0] ssrx_char_t;
  typedef logic [`SSRX_OUT_W-1:0] ssrx_out_t;
  typedef logic [`SSRX_ENT_W-1:0] ssrx_entry_t;

endpackage : ssrx_pkg

/* File: src/ssrx_stream_if.sv */
/*
  Valid/ready word stream into and out of the framer's character queue.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps

interface ssrx_stream_if #(
  parameter int W = 11
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ssrx_stream_if

/* File: src/ssrx_top.sv */
/*
  Synchronous receiver front end: configuration registers, match-character
  framing of a start/stop-free bit stream, parity check, character queue
  and holding register with status flags and floatable outputs.
  Assumes host controls arrive on CORE_CLK; serial data, bit clock and
  external frame pulse are pins and are synchronised here. The bit clock
  must be well below a quarter of CORE_CLK.
*/
`timescale 1ns/1ps

module ssrx_top
  import ssrx_pkg::*;
#(
  parameter int FIFO_DEPTH = `SSRX_FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  // serial line pins
  input wire logic RX_SERIAL_IN,
  input wire logic RX_BIT_CLK,
  input wire logic EXT_FRAME_IN,
  // configuration
  input wire logic OUTPUT_FLOAT_CTL,
  input wire ssrx_pkg::ssrx_mode_t RECEIVE_MODE_SELECT,
  input wire ssrx_pkg::ssrx_wls_t WORD_LENGTH_SELECT,
  input wire logic PARITY_OFF,
  input wire logic EVEN_PARITY_SEL,
  input wire logic CONTROL_REG_LOAD,
  input wire ssrx_pkg::ssrx_char_t MATCH_CHAR_IN,
  input wire logic MATCH_CHAR_LOAD,
  // flag control
  input wire logic CLEAR_RECEIVED_FLAG,
  input wire logic CLEAR_ERROR_FLAGS,
  input wire logic SYNC_SEARCH,
  // character and status outputs
  output logic [`SSRX_OUT_W-1:0] RX_CHAR_OUT,
  output logic RX_CHAR_OUT_OE,
  output logic CHAR_RECEIVED_FLAG,
  output logic SYNC_MATCH_FLAG,
  output logic PARITY_ERR_FLAG,
  output logic FRAMING_ERR_FLAG,
  output logic OVERRUN_FLAG,
  output logic STATUS_OE,
  output logic FRAMED
);
  import ssrx_pkg::*;

  // ************************************************************
  // pin synchronisers and bit strobe
  // ************************************************************
  logic [2:0] bclk_q, bclk_d;
  logic [1:0] sdat_q, sdat_d;
  logic [1:0] efr_q, efr_d;
  logic bit_stb;
  logic bit_val;

  always_comb begin
    bclk_d = {bclk_q[1:0], RX_BIT_CLK};
    sdat_d = {sdat_q[0], RX_SERIAL_IN};
    efr_d = {efr_q[0], EXT_FRAME_IN};
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bclk_q <= '0;
      sdat_q <= '0;
      efr_q <= '0;
    end else if (CLK_EN) begin
      bclk_q <= bclk_d;
      sdat_q <= sdat_d;
      efr_q <= efr_d;
    end
  end

  assign bit_stb = bclk_q[1] && !bclk_q[2];
  assign bit_val = sdat_q[1];

  // ************************************************************
  // control and match registers
  // ************************************************************
  logic cfg_en;
  ssrx_mode_t mode_q, mode_d;
  ssrx_wls_t wls_q, wls_d;
  logic par_off_q, par_off_d;
  logic even_q, even_d;
  ssrx_char_t match_q, match_d;
  logic [`SSRX_CNT_W-1:0] wl;
  ssrx_char_t wl_mask;
  logic ext_mode;

  assign cfg_en = !OUTPUT_FLOAT_CTL;
  assign wl = `SSRX_WL_BASE + {2'h0, wls_q};
  assign wl_mask = 8'hFF >> (`SSRX_WL_MAX - wl);
  assign ext_mode = (mode_q == `SSRX_MODE_SYNC_EXT);

  always_comb begin
    mode_d = mode_q;
    wls_d = wls_q;
    par_off_d = par_off_q;
    even_d = even_q;
    match_d = match_q;
    if (cfg_en && CONTROL_REG_LOAD) begin
      mode_d = RECEIVE_MODE_SELECT;
      wls_d = WORD_LENGTH_SELECT;
      par_off_d = PARITY_OFF;
      even_d = EVEN_PARITY_SEL;
    end
    if (cfg_en && MATCH_CHAR_LOAD) begin
      match_d = MATCH_CHAR_IN & wl_mask;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mode_q <= `SSRX_MODE_RST;
      wls_q <= `SSRX_WLS_RST;
      par_off_q <= `SSRX_PAR_OFF_RST;
      even_q <= `SSRX_EVEN_RST;
      match_q <= `SSRX_MATCH_RST;
    end else if (CLK_EN) begin
      mode_q <= mode_d;
      wls_q <= wls_d;
      par_off_q <= par_off_d;
      even_q <= even_d;
      match_q <= match_d;
    end
  end

  // ************************************************************
  // framer
  // ************************************************************
  ssrx_state_t st_q, st_d;
  ssrx_char_t sh_q, sh_d;
  logic [`SSRX_CNT_W-1:0] cnt_q, cnt_d;
  logic [`SSRX_CNT_W-1:0] fill_q, fill_d;
  ssrx_char_t win, win_next;
  logic push_v;
  ssrx_entry_t push_data;
  logic fe_set;
  logic [`SSRX_CNT_W-1:0] last_idx;
  logic hit;

  ssrx_stream_if #(.W(`SSRX_ENT_W)) q_in ();
  ssrx_stream_if #(.W(`SSRX_ENT_W)) q_out ();

  assign win = sh_q >> (`SSRX_WL_MAX - wl);
  assign win_next = {bit_val, sh_q[7:1]} >> (`SSRX_WL_MAX - wl);
  assign last_idx = par_off_q ? wl - 4'h1 : wl;
  assign hit = ext_mode ? efr_q[1] : (fill_q >= wl - 4'h1 && win_next == match_q);

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    fill_d = fill_q;
    push_v = 1'b0;
    push_data = '0;
    fe_set = 1'b0;
    if (SYNC_SEARCH) begin
      st_d = SSRX_HUNT;
      fill_d = '0;
    end else if (bit_stb) begin
      unique case (st_q)
        SSRX_HUNT: begin
          sh_d = {bit_val, sh_q[7:1]};
          if (fill_q != `SSRX_WL_MAX) begin
            fill_d = fill_q + 4'h1;
          end
          if (hit) begin
            st_d = SSRX_ASM;
            cnt_d = '0;
            push_v = 1'b1;
            push_data = {1'b1, 2'h0, win_next};
          end
        end
        SSRX_ASM: begin
          if (cnt_q < wl) begin
            sh_d = {bit_val, sh_q[7:1]};
          end
          if (ext_mode && efr_q[1] && cnt_q != last_idx) begin
            fe_set = 1'b1;
          end
          if (cnt_q == last_idx) begin
            cnt_d = '0;
            push_v = 1'b1;
            if (par_off_q) begin
              push_data = {3'h0, win_next};
            end else begin
              push_data = {1'b0, (^win ^ bit_val) == even_q, bit_val, win};
            end
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
        default: begin
          st_d = SSRX_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_q <= SSRX_HUNT;
      sh_q <= '0;
      cnt_q <= '0;
      fill_q <= '0;
    end else if (CLK_EN) begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      fill_q <= fill_d;
    end
  end

  assign q_in.valid = push_v;
  assign q_in.data = push_data;

  ssrx_fifo #(
    .W(`SSRX_ENT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst(RST),
    .ce(CLK_EN),
    .wr(q_in),
    .rd(q_out)
  );

  // ************************************************************
  // holding register and flags
  // ************************************************************
  ssrx_out_t hold_q, hold_d;
  logic dr_q, dr_d;
  logic md_q, md_d;
  logic pe_q, pe_d;
  logic fe_q, fe_d;
  logic oe_q, oe_d;
  logic drive_q, drive_d;
  logic framed_q, framed_d;
  logic pop;
  logic clr_dr, clr_err;

  assign pop = q_out.valid && !dr_q && !md_q;
  assign q_out.ready = pop;
  assign clr_dr = cfg_en && CLEAR_RECEIVED_FLAG;
  assign clr_err = cfg_en && CLEAR_ERROR_FLAGS;

  always_comb begin
    hold_d = hold_q;
    dr_d = dr_q && !clr_dr;
    md_d = md_q && !clr_dr;
    pe_d = pe_q && !clr_err;
    fe_d = (fe_q && !clr_err) || fe_set;
    oe_d = (oe_q && !clr_err) || (push_v && !q_in.ready);
    drive_d = !OUTPUT_FLOAT_CTL;
    framed_d = (st_d == SSRX_ASM);
    if (pop) begin
      hold_d = q_out.data[`SSRX_OUT_W-1:0];
      pe_d = pe_d || q_out.data[`SSRX_ENT_PERR];
      if (q_out.data[`SSRX_ENT_SYNC]) begin
        md_d = 1'b1;
      end else begin
        dr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      hold_q <= '0;
      dr_q <= 1'b0;
      md_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      oe_q <= 1'b0;
      drive_q <= 1'b1;
      framed_q <= 1'b0;
    end else if (CLK_EN) begin
      hold_q <= hold_d;
      dr_q <= dr_d;
      md_q <= md_d;
      pe_q <= pe_d;
      fe_q <= fe_d;
      oe_q <= oe_d;
      drive_q <= drive_d;
      framed_q <= framed_d;
    end
  end

  assign RX_CHAR_OUT = hold_q;
  assign RX_CHAR_OUT_OE = drive_q;
  assign STATUS_OE = drive_q;
  assign CHAR_RECEIVED_FLAG = dr_q;
  assign SYNC_MATCH_FLAG = md_q;
  assign PARITY_ERR_FLAG = pe_q;
  assign FRAMING_ERR_FLAG = fe_q;
  assign OVERRUN_FLAG = oe_q;
  assign FRAMED = framed_q;
endmodule : ssrx_top

/* File: tb/ssrx_line_model.sv */
/*
  Serial line partner: bit clock and data of a start/stop-free stream.
  Assumes the bench calls send from a CORE_CLK-synchronous process.
*/
`timescale 1ns/1ps

module ssrx_line (
  // clock
  input wire logic clk,
  // line pins
  output logic bit_clk,
  output logic ser,
  output logic frame
);
  initial begin
    bit_clk = 1'h0;
    ser = 1'h0;
    frame = 1'h0;
  end

  // lsb first, bit clock still between frames
  // mark raises the frame pin during the last bit sent
  task automatic send(input logic [15:0] v, input int n, input logic mark = 1'h0);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ser <= v[i];
      frame <= mark && (i == n - 1);
      repeat (3) @(posedge clk);
      bit_clk <= 1'h1;
      repeat (4) @(posedge clk);
      bit_clk <= 1'h0;
    end
    @(posedge clk);
    ser <= ~v[n-1];
    frame <= 1'h0;
  endtask : send
endmodule : ssrx_line

/* File: tb/ssrx_top_sva.sv */
/*
  Port-level assertions of the receiver top.
  Assumes one clock domain; attached by the bind at the foot.
*/
`timescale 1ns/1ps
`include "ssrx_defs.svh"

module ssrx_chk (
  // clock and controls
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic OUTPUT_FLOAT_CTL,
  input wire logic CLEAR_RECEIVED_FLAG,
  input wire logic CLEAR_ERROR_FLAGS,
  input wire logic SYNC_SEARCH,
  // outputs
  input wire logic [`SSRX_OUT_W-1:0] RX_CHAR_OUT,
  input wire logic RX_CHAR_OUT_OE,
  input wire logic CHAR_RECEIVED_FLAG,
  input wire logic SYNC_MATCH_FLAG,
  input wire logic PARITY_ERR_FLAG,
  input wire logic OVERRUN_FLAG,
  input wire logic STATUS_OE,
  input wire logic FRAMED
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  wire logic en_clr = CLK_EN && !OUTPUT_FLOAT_CTL && CLEAR_RECEIVED_FLAG;

  property p_float_off;
    CLK_EN && OUTPUT_FLOAT_CTL |=> !RX_CHAR_OUT_OE && !STATUS_OE;
  endproperty
  a_float_off: assert property (p_float_off) else $error("outputs not released");
  property p_float_on;
    CLK_EN && !OUTPUT_FLOAT_CTL |=> RX_CHAR_OUT_OE && STATUS_OE;
  endproperty
  a_float_on: assert property (p_float_on) else $error("outputs not driven");
  property p_clr_rx;
    en_clr |=> !CHAR_RECEIVED_FLAG && !SYNC_MATCH_FLAG;
  endproperty
  a_clr_rx: assert property (p_clr_rx) else $error("received flags not cleared");
  property p_clr_blocked;
    OUTPUT_FLOAT_CTL && CHAR_RECEIVED_FLAG && !SYNC_SEARCH |=> CHAR_RECEIVED_FLAG;
  endproperty
  a_clr_blocked: assert property (p_clr_blocked) else $error("clear acted while floated");
  property p_par_sticky;
    PARITY_ERR_FLAG && !(CLEAR_ERROR_FLAGS && !OUTPUT_FLOAT_CTL) |=> PARITY_ERR_FLAG;
  endproperty
  a_par_sticky: assert property (p_par_sticky) else $error("parity flag lost");
  property p_ovr_sticky;
    OVERRUN_FLAG && !(CLEAR_ERROR_FLAGS && !OUTPUT_FLOAT_CTL) |=> OVERRUN_FLAG;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun flag lost");
  property p_sync_not_rx;
    $rose(SYNC_MATCH_FLAG) |-> !$rose(CHAR_RECEIVED_FLAG);
  endproperty
  a_sync_not_rx: assert property (p_sync_not_rx) else $error("sync raised data flag");
  property p_hold_stable;
    (CHAR_RECEIVED_FLAG || SYNC_MATCH_FLAG) && !en_clr && !SYNC_SEARCH |=> $stable(RX_CHAR_OUT);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("held char changed");
  property p_sync_framed;
    $rose(SYNC_MATCH_FLAG) |-> FRAMED;
  endproperty
  a_sync_framed: assert property (p_sync_framed) else $error("match without framing");
  property p_stay_framed;
    FRAMED && !SYNC_SEARCH |=> FRAMED;
  endproperty
  a_stay_framed: assert property (p_stay_framed) else $error("framing lost");
endmodule : ssrx_chk

bind ssrx_top ssrx_chk u_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN), .OUTPUT_FLOAT_CTL(OUTPUT_FLOAT_CTL),
  .CLEAR_RECEIVED_FLAG(CLEAR_RECEIVED_FLAG), .CLEAR_ERROR_FLAGS(CLEAR_ERROR_FLAGS),
  .SYNC_SEARCH(SYNC_SEARCH), .RX_CHAR_OUT(RX_CHAR_OUT), .RX_CHAR_OUT_OE(RX_CHAR_OUT_OE),
  .CHAR_RECEIVED_FLAG(CHAR_RECEIVED_FLAG), .SYNC_MATCH_FLAG(SYNC_MATCH_FLAG),
  .PARITY_ERR_FLAG(PARITY_ERR_FLAG), .OVERRUN_FLAG(OVERRUN_FLAG), .STATUS_OE(STATUS_OE),
  .FRAMED(FRAMED));

/* File: tb/tb_top.sv */
/*
  Self-checking bench of the receiver top.
  Assumes ssrx_line drives the serial pins.
*/
`timescale 1ns/1ps
`include "ssrx_defs.svh"

module tb_top;
  import ssrx_pkg::*;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic float_ctl = 1'h0;
  ssrx_mode_t mode = `SSRX_MODE_SYNC_INT;
  ssrx_wls_t wls = 2'h3;
  logic par_off = 1'h1;
  logic even_sel = 1'h0;
  logic ctl_load = 1'h0;
  ssrx_char_t match_in = 8'h00;
  logic match_load = 1'h0;
  logic clr_rx = 1'h0;
  logic clr_err = 1'h0;
  logic search = 1'h0;
  logic bit_clk, ser, rx_oe, rx_flag, match_flag, par_err, frm_err, ovr, st_oe, framed;
  logic ext_frame;
  logic [`SSRX_OUT_W-1:0] rx_char;
  wire logic [8:0] flags = {4'h0, ovr, par_err, frm_err, match_flag, rx_flag};
  wire logic [8:0] misc = {6'h00, framed, rx_oe, st_oe};
  int fail_count = 0;
  int compares = 0;

  always #10 core_clk = ~core_clk;

  ssrx_line line (.clk(core_clk), .bit_clk(bit_clk), .ser(ser), .frame(ext_frame));
  ssrx_top dut (
    .CORE_CLK(core_clk), .RST(rst), .CLK_EN(1'h1), .RX_SERIAL_IN(ser), .RX_BIT_CLK(bit_clk),
    .EXT_FRAME_IN(ext_frame), .OUTPUT_FLOAT_CTL(float_ctl), .RECEIVE_MODE_SELECT(mode),
    .WORD_LENGTH_SELECT(wls), .PARITY_OFF(par_off), .EVEN_PARITY_SEL(even_sel),
    .CONTROL_REG_LOAD(ctl_load), .MATCH_CHAR_IN(match_in), .MATCH_CHAR_LOAD(match_load),
    .CLEAR_RECEIVED_FLAG(clr_rx), .CLEAR_ERROR_FLAGS(clr_err), .SYNC_SEARCH(search),
    .RX_CHAR_OUT(rx_char), .RX_CHAR_OUT_OE(rx_oe), .CHAR_RECEIVED_FLAG(rx_flag),
    .SYNC_MATCH_FLAG(match_flag), .PARITY_ERR_FLAG(par_err), .FRAMING_ERR_FLAG(frm_err),
    .OVERRUN_FLAG(ovr), .STATUS_OE(st_oe), .FRAMED(framed));

  // *****
  // helpers
  // *****
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // settle past the edge before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic pulse_clr_rx;
    @(posedge core_clk);
    clr_rx <= 1'h1;
    @(posedge core_clk);
    clr_rx <= 1'h0;
    tick(3);
  endtask : pulse_clr_rx

  task automatic pulse_clr_err;
    @(posedge core_clk);
    clr_err <= 1'h1;
    @(posedge core_clk);
    clr_err <= 1'h0;
    tick(3);
  endtask : pulse_clr_err

  // control first, so the match mask uses the new length
  task automatic configure(input ssrx_wls_t w, input logic po, input logic ev,
    input ssrx_char_t m, input ssrx_mode_t md = `SSRX_MODE_SYNC_INT);
    @(posedge core_clk);
    mode <= md;
    wls <= w;
    par_off <= po;
    even_sel <= ev;
    ctl_load <= 1'h1;
    @(posedge core_clk);
    ctl_load <= 1'h0;
    match_in <= m;
    match_load <= 1'h1;
    @(posedge core_clk);
    match_load <= 1'h0;
    search <= 1'h1;
    @(posedge core_clk);
    search <= 1'h0;
  endtask : configure

  // *****
  // scenarios
  // *****
  task automatic test_reset;
    tick(1);
    check(flags, 9'h000);
    check(rx_char, 9'h000);
    check(misc, 9'h003);
  endtask : test_reset

  // sync, then overfill the queue and drain it in order
  task automatic test_sync_fifo;
    configure(2'h3, 1'h1, 1'h0, 8'hA5);
    line.send(16'h00A5, 8);
    for (int i = 0; i < 9; i++) begin
      line.send({8'h00, 8'h30 + 8'(i)}, 8);
    end
    tick(6);
    check(rx_char, 9'h0A5);
    check(flags, 9'h012);
    check(misc, 9'h007);
    for (int i = 0; i < 8; i++) begin
      pulse_clr_rx;
      check(rx_char, {1'h0, 8'h30 + 8'(i)});
      check(flags, 9'h011);
    end
    pulse_clr_rx;
    check(flags, 9'h010);
    pulse_clr_err;
    check(flags, 9'h000);
  endtask : test_sync_fifo

  // lengths 5..7, masked match, even parity good and bad
  task automatic test_lengths;
    logic [7:0] mask;
    logic [7:0] d;
    int len;
    for (int w = 0; w < 3; w++) begin
      len = w + 5;
      mask = 8'hFF >> (3 - w);
      d = 8'h55 & mask;
      configure(ssrx_wls_t'(w), 1'h0, 1'h1, 8'hF6);
      line.send({8'h00, 8'hF6 & mask}, len);
      line.send({8'h00, d} | (16'(^d) << len), len + 1);
      tick(6);
      check(flags, 9'h002);
      pulse_clr_rx;
      check(rx_char, {^d, d});
      line.send({8'h00, d} | (16'(~^d) << len), len + 1);
      tick(6);
      pulse_clr_rx;
      check(flags, 9'h009);
      pulse_clr_err;
      pulse_clr_rx;
      check(flags, 9'h000);
    end
  endtask : test_lengths

  // external frame pulse syncs, a pulse inside a character is a framing error
  task automatic test_external;
    configure(2'h3, 1'h1, 1'h0, 8'h00, `SSRX_MODE_SYNC_EXT);
    line.send(16'h003C, 8, 1'h1);
    line.send(16'h005A, 8);
    line.send(16'h000F, 4, 1'h1);
    line.send(16'h0000, 4);
    tick(6);
    check(rx_char, 9'h03C);
    check(flags, 9'h006);
    pulse_clr_rx;
    check(rx_char, 9'h05A);
    pulse_clr_rx;
    check(rx_char, 9'h00F);
    check(flags, 9'h005);
    pulse_clr_err;
    pulse_clr_rx;
    check(flags, 9'h000);
  endtask : test_external

  // float releases outputs and blocks a clear
  task automatic test_float;
    line.send(16'h0055, 8);
    tick(6);
    @(posedge core_clk);
    float_ctl <= 1'h1;
    clr_rx <= 1'h1;
    tick(2);
    check(misc, 9'h004);
    check(flags, 9'h001);
    @(posedge core_clk);
    float_ctl <= 1'h0;
    clr_rx <= 1'h0;
    tick(2);
    check(misc, 9'h007);
    check(flags, 9'h001);
  endtask : test_float

  task automatic wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #400000;
    fail_count++;
    wrap_up;
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'h0;
    test_reset;
    test_sync_fifo;
    test_lengths;
    test_external;
    test_float;
    wrap_up;
  end
endmodule : tb_top
